// ==== rtl/mit_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mit_regs.svh"
// Contract
// - external read via 16-bit data pointer takes 3 cycles
// - external write via 8-bit indirect address takes 3 cycles
// - code byte fetch at acc plus pointer takes 3 cycles, one byte
// - load data pointer from 16-bit immediate: 3 bytes, 3 cycles
// - test, clear and branch: 3 bytes, 3 cycles or 4 taken
// - compare immediate to indirect RAM and branch: 4 or 5 cycles
// - compare immediate to bank register and branch: 3 bytes, 3 or 4
// - decrement bank register, branch nonzero: 2 bytes, 2 or 3
// - branch on accumulator nonzero: 2 bytes, 2 or 3 cycles
// - branch on carry clear: 2 bytes, 2 or 3 cycles
// - short relative branch: 2 bytes, 3 cycles
// - jump to accumulator plus data pointer: 1 byte, 3 cycles
// - logic op immediate into direct byte: 3 bytes, 3 cycles
// - low nibble exchange with indirect RAM takes 2 cycles
// - nine-bit rotate left through carry takes 1 cycle
// - push direct byte: 2 bytes, 2 cycles
// - and inverse bit into carry: 2 bytes, 2 cycles
// - relative offset is signed 8-bit, added to next address
// - direct addresses up to 0x7F are RAM, 0x80 up SPECIAL_FUNCTION_REGISTER
// - paged targets replace low 11 bits of next address
// - full 16-bit targets reach anywhere in program space
// - opcode 0xA5 acts as one-byte one-cycle no-operation
// - a failed conditional branch finishes one cycle sooner
// - most instructions take as many cycles as bytes
module mit_decoder
  import mit_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] acc_i,
  input wire logic [15:0] data_pointer_16_i,
  input wire logic cond_true_i,
  output logic byte_ready_o,
  output logic busy_o,
  output logic done_o,
  output mit_res_t result_o
);
  // =====================================================================
  // state
  // =====================================================================
  typedef enum logic [1:0] {
    MIT_ST_OPCODE,
    MIT_ST_OPERAND,
    MIT_ST_EXEC
  } mit_state_t;

  typedef struct packed {
    mit_state_t st;
    logic [7:0] opcode;
    logic [15:0] start_pc;
    logic [7:0] mid_byte;
    logic [7:0] last_byte;
    logic [1:0] got;
    logic [3:0] remain;
    logic extra;
    logic done;
    mit_res_t res;
  } mit_core_t;

  mit_core_t cur;
  mit_core_t next_cur;
  mit_dec_t dec_live;
  mit_dec_t dec_held;
  logic [15:0] target;
  logic [3:0] total;
  logic taken;
  logic [7:0] direct_addr;

  // =====================================================================
  // decode and target units
  // =====================================================================
  mit_opcode_table u_live (
    .opcode_i(byte_i),
    .dec_o(dec_live)
  );

  mit_opcode_table u_held (
    .opcode_i(cur.opcode),
    .dec_o(dec_held)
  );

  mit_target_calc u_target (
    .tgt_i(dec_held.tgt),
    .opcode_i(cur.opcode),
    .last_byte_i(cur.last_byte),
    .mid_byte_i(cur.mid_byte),
    .next_pc_i(cur.start_pc + {14'h0000, dec_held.length}),
    .acc_i(acc_i),
    .data_pointer_16_i(data_pointer_16_i),
    .target_o(target)
  );

  // =====================================================================
  // timing
  // =====================================================================
  // taken decided from the outside condition once all bytes are in;
  // unconditional branches always count as taken, so the extra cycle
  // applies only to conditional ones
  always_comb begin
    // once the owed cycle has started the branch stays taken
    taken = (dec_held.tgt != MIT_TGT_NONE) && (!dec_held.is_cond || cond_true_i || cur.extra);
    total = dec_held.cycles_base + {3'h0, dec_held.is_cond && taken};
    direct_addr = (dec_held.length == 2'h3 && !dec_held.is_cond) ? cur.mid_byte
                  : (dec_held.length == 2'h3 ? cur.mid_byte : cur.last_byte);
  end

  // one byte taken per cycle; the machine never accepts while executing
  assign byte_ready_o = (cur.st != MIT_ST_EXEC);
  assign busy_o = (cur.st != MIT_ST_OPCODE);
  assign done_o = cur.done;
  assign result_o = cur.res;

  // =====================================================================
  // next state
  // =====================================================================
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    unique case (cur.st)
      MIT_ST_OPCODE: begin
        if (byte_valid_i) begin
          next_cur.opcode = byte_i;
          next_cur.start_pc = pc_i;
          next_cur.got = 2'h1;
          next_cur.extra = 1'b0;
          next_cur.mid_byte = 8'h00;
          next_cur.last_byte = 8'h00;
          // first cycle already spent fetching the opcode
          next_cur.remain = dec_live.cycles_base - 4'h1;
          if (dec_live.length == 2'h1) begin
            next_cur.st = MIT_ST_EXEC;
          end else begin
            next_cur.st = MIT_ST_OPERAND;
          end
        end
      end
      MIT_ST_OPERAND: begin
        if (byte_valid_i) begin
          next_cur.got = cur.got + 2'h1;
          next_cur.last_byte = byte_i;
          if (cur.got == 2'h1 && dec_held.length == 2'h3) next_cur.mid_byte = byte_i;
          if (cur.remain != 4'h0) next_cur.remain = cur.remain - 4'h1;
          if (cur.got + 2'h1 == dec_held.length) next_cur.st = MIT_ST_EXEC;
        end
      end
      MIT_ST_EXEC: begin
        // operand bytes were counted against the cycle budget already; a taken
        // conditional branch owes one cycle more before it may finish
        if (cur.remain != 4'h0) begin
          next_cur.remain = cur.remain - 4'h1;
        end else if (dec_held.is_cond && taken && !cur.extra) begin
          next_cur.extra = 1'b1;
        end else begin
          next_cur.st = MIT_ST_OPCODE;
          next_cur.done = 1'b1;
          next_cur.res.opcode = cur.opcode;
          next_cur.res.length = dec_held.length;
          next_cur.res.cycles = total;
          next_cur.res.taken = taken;
          next_cur.res.target = taken ? target
                                : cur.start_pc + {14'h0000, dec_held.length};
          next_cur.res.has_direct = dec_held.has_direct;
          next_cur.res.direct_is_sfr = dec_held.has_direct
                                       && (direct_addr >= `MIT_OP_DIRECT_SFR_MIN);
        end
      end
      default: next_cur.st = MIT_ST_OPCODE;
    endcase
  end

  // =====================================================================
  // registers
  // =====================================================================
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule : mit_decoder
`default_nettype wire

// ==== shared/mit_regs.svh ====
`ifndef MIT_REGS_SVH
`define MIT_REGS_SVH
// opcode value, direct address bound and address widths of the classic accumulator instruction set
`define MIT_OP_NOP_ALT 8'hA5
`define MIT_OP_DIRECT_SFR_MIN 8'h80
`define MIT_PAGE_BITS 11
`define MIT_PROG_ADDR_BITS 13
// cycle counts
`define MIT_CYC_MUL 4'h4
`define MIT_CYC_DIV 4'h8
`define MIT_CYC_RET 4'h5
`define MIT_CYC_LONG 4'h4
`define MIT_CYC_XDATA 4'h3
`define MIT_CYC_CODE 4'h3
`define MIT_CYC_PAGED 4'h3
`endif

// ==== shared/mit_pkg.sv ====
package mit_pkg;
  // addressing class of the operand fields
  typedef enum logic [2:0] {
    MIT_TGT_NONE,
    MIT_TGT_REL,
    MIT_TGT_PAGED,
    MIT_TGT_FULL,
    MIT_TGT_INDEXED
  } mit_tgt_t;

  // static decode of one opcode
  typedef struct packed {
    logic [1:0] length;
    logic [3:0] cycles_base;
    logic is_cond;
    mit_tgt_t tgt;
    logic has_direct;
    logic is_nop;
  } mit_dec_t;

  // result handed out for one finished instruction
  typedef struct packed {
    logic [7:0] opcode;
    logic [1:0] length;
    logic [3:0] cycles;
    logic taken;
    logic [15:0] target;
    logic direct_is_sfr;
    logic has_direct;
  } mit_res_t;
endpackage : mit_pkg

// ==== rtl/mit_opcode_table.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mit_regs.svh"
module mit_opcode_table
  import mit_pkg::*;
(
  input wire logic [7:0] opcode_i,
  output mit_dec_t dec_o
);
  // =====================================================================
  // opcode classification
  // =====================================================================
  // lengths and base cycles; a conditional branch adds one cycle when taken
  always_comb begin
    dec_o = '{length: 2'h1, cycles_base: 4'h1, is_cond: 1'b0, tgt: MIT_TGT_NONE,
              has_direct: 1'b0, is_nop: 1'b0};
    if (opcode_i[3:0] == 4'h1) begin
      // paged branch or paged call: 11-bit target
      dec_o.length = 2'h2;
      dec_o.cycles_base = `MIT_CYC_PAGED;
      dec_o.tgt = MIT_TGT_PAGED;
    end else if (opcode_i[7:4] == 4'hB && opcode_i[3:0] >= 4'h4) begin
      // compare_branch_unequal family
      dec_o.length = 2'h3;
      dec_o.is_cond = 1'b1;
      dec_o.tgt = MIT_TGT_REL;
      dec_o.has_direct = (opcode_i[3:0] == 4'h5);
      dec_o.cycles_base = (opcode_i[3:0] == 4'h6 || opcode_i[3:0] == 4'h7) ? 4'h4 : 4'h3;
    end else if (opcode_i[7:4] == 4'hD && opcode_i[3:0] >= 4'h8) begin
      dec_o.length = 2'h2;
      dec_o.cycles_base = 4'h2;
      dec_o.is_cond = 1'b1;
      dec_o.tgt = MIT_TGT_REL;
    end else if (opcode_i[7:4] >= 4'h8 && opcode_i[3:0] >= 4'h6) begin
      // indirect and bank register forms: 1 byte, 2 bytes in rows 8 and A, which carry a direct byte
      dec_o.cycles_base = (opcode_i[3:0] >= 4'h8) ? 4'h1 : 4'h2;
      if (opcode_i == 8'h86 || opcode_i == 8'h87 || opcode_i[7:4] == 4'hA && opcode_i[3]
          || opcode_i[7:4] == 4'h8 && opcode_i[3] || opcode_i[7:4] == 4'h7 && opcode_i[3])
        dec_o.length = 2'h2;
      if (opcode_i[7:4] == 4'h8 || opcode_i == 8'hA6 || opcode_i == 8'hA7) begin
        dec_o.has_direct = 1'b1;
        dec_o.length = 2'h2;
      end
      if (opcode_i[7:4] == 4'hA && opcode_i[3]) dec_o.has_direct = 1'b1;
      if (opcode_i[7:4] == 4'h8 && opcode_i[3]) dec_o.cycles_base = 4'h2;
      if (opcode_i[7:4] == 4'hA && opcode_i[3]) dec_o.cycles_base = 4'h2;
      if (opcode_i[7:4] == 4'hE || opcode_i[7:4] == 4'hF) dec_o.length = 2'h1;
    end else if (opcode_i[3:1] == 3'h3 || opcode_i[3]) begin
      // low-row indirect (x6/x7) and bank register (x8..xF) for rows 0..7
      dec_o.cycles_base = opcode_i[3] ? 4'h1 : 4'h2;
      if (opcode_i[7:4] == 4'h7) begin
        dec_o.length = 2'h2; // move immediate to indirect/bank register
        dec_o.cycles_base = 4'h2;
      end
    end else begin
      unique case (opcode_i)
        8'h00, `MIT_OP_NOP_ALT: dec_o.is_nop = 1'b1;
        8'h02, 8'h12: begin
          dec_o.length = 2'h3;
          dec_o.cycles_base = `MIT_CYC_LONG;
          dec_o.tgt = MIT_TGT_FULL;
        end
        8'h22, 8'h32: dec_o.cycles_base = `MIT_CYC_RET;
        8'h10, 8'h20, 8'h30: begin
          dec_o.length = 2'h3;
          dec_o.cycles_base = 4'h3;
          dec_o.is_cond = 1'b1;
          dec_o.tgt = MIT_TGT_REL;
          dec_o.has_direct = 1'b1;
        end
        8'h40, 8'h50, 8'h60, 8'h70: begin
          dec_o.length = 2'h2;
          dec_o.cycles_base = 4'h2;
          dec_o.is_cond = 1'b1;
          dec_o.tgt = MIT_TGT_REL;
        end
        8'h80: begin
          dec_o.length = 2'h2;
          dec_o.cycles_base = 4'h3;
          dec_o.tgt = MIT_TGT_REL;
        end
        8'h73: begin
          dec_o.cycles_base = 4'h3;
          dec_o.tgt = MIT_TGT_INDEXED;
        end
        8'h83, 8'h93: dec_o.cycles_base = `MIT_CYC_CODE;
        8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3:
          dec_o.cycles_base = `MIT_CYC_XDATA;
        8'h90: begin
          dec_o.length = 2'h3;
          dec_o.cycles_base = 4'h3;
        end
        8'hA4: dec_o.cycles_base = `MIT_CYC_MUL;
        8'h84: dec_o.cycles_base = `MIT_CYC_DIV;
        8'h43, 8'h53, 8'h63, 8'h75, 8'h85: begin
          dec_o.length = 2'h3;
          dec_o.cycles_base = 4'h3;
          dec_o.has_direct = 1'b1;
        end
        8'h33, 8'h03, 8'h13, 8'h23, 8'hC4, 8'hD4, 8'hE4, 8'hF4, 8'hC3, 8'hD3, 8'hB3,
        8'h04, 8'h14, 8'hA3:
          dec_o.cycles_base = 4'h1;
        8'h05, 8'h15, 8'h42, 8'h52, 8'h62, 8'hC0, 8'hD0, 8'hA2, 8'hB2, 8'hC2, 8'hD2,
        8'h72, 8'h82, 8'hA0, 8'hB0, 8'h92, 8'hE5, 8'hF5, 8'hC5, 8'h25, 8'h35, 8'h95,
        8'h45, 8'h55, 8'h65: begin
          dec_o.length = 2'h2;
          dec_o.cycles_base = 4'h2;
          dec_o.has_direct = 1'b1;
        end
        default: begin
          // immediate-to-accumulator forms: two bytes, two cycles
          dec_o.length = 2'h2;
          dec_o.cycles_base = 4'h2;
        end
      endcase
    end
  end
endmodule : mit_opcode_table
`default_nettype wire

// ==== rtl/mit_target_calc.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mit_regs.svh"
module mit_target_calc
  import mit_pkg::*;
(
  input wire mit_tgt_t tgt_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] last_byte_i,
  input wire logic [7:0] mid_byte_i,
  input wire logic [15:0] next_pc_i,
  input wire logic [7:0] acc_i,
  input wire logic [15:0] data_pointer_16_i,
  output logic [15:0] target_o
);
  // =====================================================================
  // branch target arithmetic
  // =====================================================================
  always_comb begin
    unique case (tgt_i)
      MIT_TGT_REL: // sign-extended displacement from the following byte
        target_o = next_pc_i + {{8{last_byte_i[7]}}, last_byte_i};
      MIT_TGT_PAGED: // page bits stay, low 11 bits replaced
        target_o = {next_pc_i[15:`MIT_PAGE_BITS], opcode_i[7:5], last_byte_i};
      MIT_TGT_FULL:
        target_o = {mid_byte_i, last_byte_i};
      MIT_TGT_INDEXED:
        target_o = data_pointer_16_i + {8'h00, acc_i};
      default:
        target_o = next_pc_i;
    endcase
  end
endmodule : mit_target_calc
`default_nettype wire

// ==== dv/mit_decoder_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// timing properties seen at the decoder's ports
module mit_decoder_properties
  import mit_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire mit_res_t result_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  // one finished instruction of the given opcode
  sequence s_fin(logic [7:0] op);
    done_o && result_o.opcode == op;
  endsequence
  // the slowest form, the one-byte eight-cycle divide, ends well inside this span
  sequence s_finish;
    ##[0:12] done_o;
  endsequence

  chk_done_pulse: assert property (done_o |=> !done_o)
    else $error("done held longer than one cycle");
  chk_result_hold: assert property (!done_o |-> $stable(result_o))
    else $error("result moved without done");
  chk_busy_bound: assert property (busy_o |-> s_finish)
    else $error("busy without finishing in time");
  chk_nop_alt: assert property (s_fin(8'hA5) |->
    result_o.length == 2'h1 && result_o.cycles == 4'h1 && !result_o.taken)
    else $error("alternate no-operation timing wrong");
  chk_cond_extra: assert property (done_o && (result_o.opcode == 8'h50 ||
    result_o.opcode == 8'h70 || result_o.opcode == 8'hD8) |->
    result_o.cycles == 4'h2 + result_o.taken)
    else $error("two-byte branch cycles wrong");
  chk_cmp_indirect: assert property (s_fin(8'hB6) |->
    result_o.cycles == 4'h4 + result_o.taken)
    else $error("indirect compare cycles wrong");
  chk_mul_four: assert property (s_fin(8'hA4) |-> result_o.cycles == 4'h4)
    else $error("multiply cycles wrong");
  chk_div_eight: assert property (s_fin(8'h84) |-> result_o.cycles == 4'h8)
    else $error("divide cycles wrong");
  chk_ret_five: assert property (done_o && (result_o.opcode == 8'h22 ||
    result_o.opcode == 8'h32) |-> result_o.cycles == 4'h5)
    else $error("return cycles wrong");
  chk_long_four: assert property (s_fin(8'h02) |->
    result_o.cycles == 4'h4 && result_o.length == 2'h3)
    else $error("long branch timing wrong");
  chk_short_fixed: assert property (s_fin(8'h80) |->
    result_o.cycles == 4'h3 && result_o.taken)
    else $error("short branch timing wrong");
endmodule : mit_decoder_properties

bind mit_decoder mit_decoder_properties i_props (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
  .busy_o(busy_o), .done_o(done_o), .result_o(result_o));
`default_nettype wire

// ==== dv/mit_decoder_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module mit_decoder_bench
  import mit_pkg::*;
;
  logic mclk_i, arst_n_i, byte_valid_i, cond_true_i;
  logic [7:0] byte_i, acc_i;
  logic [15:0] pc_i, data_pointer_16_i;
  logic byte_ready_o, busy_o, done_o;
  mit_res_t result_o;
  int n_fail = 0;
  int check_count = 0;

  mit_decoder i_mit_decoder (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .byte_valid_i(byte_valid_i),
    .byte_i(byte_i), .pc_i(pc_i), .acc_i(acc_i), .data_pointer_16_i(data_pointer_16_i),
    .cond_true_i(cond_true_i), .byte_ready_o(byte_ready_o), .busy_o(busy_o), .done_o(done_o),
    .result_o(result_o));

  // 40 MHz system clock
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // ==========================================================
  // shared helpers
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // hold the byte until ready is seen high at a taking edge
  task automatic send(input logic [7:0] b);
    logic ok;
    int n;
    n = 0;
    byte_valid_i <= 1'b1;
    byte_i <= b;
    do begin
      @(negedge mclk_i);
      ok = byte_ready_o;
      @(posedge mclk_i);
      n++;
    end while (ok !== 1'b1 && n < 40);
    if (ok !== 1'b1) chk("byte taken", 16'h1, 16'h0);
  endtask : send

  // ck: 0 timing, opcode and length only, 1 also taken, 2 also target
  task automatic run(input logic [7:0] op, b1, b2, input int len, input logic [15:0] pc,
    input bit cond, input int cyc, input bit tk, input logic [15:0] tgt, input int ck);
    int n;
    int el;
    realtime t0;
    n = 0;
    pc_i <= pc;
    cond_true_i <= cond;
    send(op);
    // send returns at the edge that took the opcode
    t0 = $realtime;
    if (len > 1) send(b1);
    if (len > 2) send(b2);
    byte_valid_i <= 1'b0;
    do begin
      @(negedge mclk_i);
      n++;
      if (n == 1) chk("busy", 16'h1, 16'(busy_o));
    end while (done_o !== 1'b1 && n < 40);
    // whole 25 ns periods from the opcode edge to the edge that raised done
    el = int'(($realtime - t0) / 25.0 - 0.5);
    chk("done", 16'h1, 16'(done_o));
    chk("elapsed", 16'(cyc), 16'(el));
    chk("busy idle", 16'h0, 16'(busy_o));
    chk("opcode", 16'(op), 16'(result_o.opcode));
    chk("length", 16'(len), 16'(result_o.length));
    chk("cycles", 16'(cyc), 16'(result_o.cycles));
    if (ck > 0) chk("taken", 16'(tk), 16'(result_o.taken));
    if (ck > 1) chk("target", tgt, result_o.target);
    @(posedge mclk_i);
  endtask : run

  // ==========================================================
  // scenarios
  task automatic t_data_moves;
    run(8'hE0, '0, '0, 1, 16'h0100, 0, 3, 0, '0, 1);
    run(8'hF2, '0, '0, 1, 16'h0101, 0, 3, 0, '0, 1);
    run(8'h93, '0, '0, 1, 16'h0102, 0, 3, 0, '0, 1);
    run(8'h90, 8'h12, 8'h34, 3, 16'h0103, 0, 3, 0, '0, 1);
    run(8'h53, 8'h7F, 8'h0F, 3, 16'h0106, 0, 3, 0, '0, 1);
    chk("has direct", 16'h1, 16'(result_o.has_direct));
    chk("ram direct", 16'h0, 16'(result_o.direct_is_sfr));
    run(8'hC0, 8'h80, '0, 2, 16'h0109, 0, 2, 0, '0, 1);
    chk("sfr direct", 16'h1, 16'(result_o.direct_is_sfr));
    run(8'hD6, '0, '0, 1, 16'h010B, 0, 2, 0, '0, 1);
    run(8'h33, '0, '0, 1, 16'h010C, 0, 1, 0, '0, 1);
    run(8'hB0, 8'h85, '0, 2, 16'h010D, 0, 2, 0, '0, 1);
    run(8'hA4, '0, '0, 1, 16'h010F, 0, 4, 0, '0, 1);
    run(8'h84, '0, '0, 1, 16'h0110, 0, 8, 0, '0, 1);
  endtask : t_data_moves

  // each conditional form falls through, then branches backwards or forwards
  task automatic t_cond_branches;
    run(8'h50, 8'hF0, '0, 2, 16'h1000, 0, 2, 0, '0, 1);
    run(8'h50, 8'hF0, '0, 2, 16'h1000, 1, 3, 1, 16'h0FF2, 2);
    run(8'h70, 8'h7F, '0, 2, 16'h1000, 0, 2, 0, '0, 1);
    run(8'h70, 8'h7F, '0, 2, 16'h1000, 1, 3, 1, 16'h1081, 2);
    run(8'hD8, 8'h80, '0, 2, 16'h1000, 0, 2, 0, '0, 1);
    run(8'hD8, 8'h80, '0, 2, 16'h1000, 1, 3, 1, 16'h0F82, 2);
    run(8'h10, 8'h20, 8'hFE, 3, 16'h1000, 0, 3, 0, '0, 1);
    run(8'h10, 8'h20, 8'hFE, 3, 16'h1000, 1, 4, 1, 16'h1001, 2);
    run(8'hB8, 8'h55, 8'h10, 3, 16'h1000, 0, 3, 0, '0, 1);
    run(8'hB8, 8'h55, 8'h10, 3, 16'h1000, 1, 4, 1, 16'h1013, 2);
    run(8'hB6, 8'h55, 8'h01, 3, 16'h1000, 0, 4, 0, '0, 1);
    run(8'hB6, 8'h55, 8'h01, 3, 16'h1000, 1, 5, 1, 16'h1004, 2);
  endtask : t_cond_branches

  // the paged branch sits so its next address crosses into the following page
  task automatic t_uncond;
    acc_i <= 8'hF0;
    data_pointer_16_i <= 16'h1F20;
    run(8'h80, 8'h80, '0, 2, 16'h0080, 0, 3, 1, 16'h0002, 2);
    run(8'h73, '0, '0, 1, 16'h0200, 0, 3, 1, 16'h2010, 2);
    run(8'hA1, 8'h34, '0, 2, 16'h07FE, 0, 3, 1, 16'h0D34, 2);
    run(8'h02, 8'h1F, 8'hFF, 3, 16'h0010, 0, 4, 1, 16'h1FFF, 2);
    run(8'h22, '0, '0, 1, 16'h0300, 0, 5, 0, '0, 0);
    run(8'h32, '0, '0, 1, 16'h0301, 0, 5, 0, '0, 0);
  endtask : t_uncond

  task automatic t_nop;
    run(8'h00, '0, '0, 1, 16'h0400, 0, 1, 0, '0, 1);
    run(8'hA5, '0, '0, 1, 16'h0401, 0, 1, 0, '0, 1);
    run(8'hA5, '0, '0, 1, 16'h0402, 1, 1, 0, '0, 1);
  endtask : t_nop

  // main sequence
  initial begin
    arst_n_i = 1'b0;
    byte_valid_i = 1'b0;
    byte_i = 8'h00;
    pc_i = 16'h0000;
    acc_i = 8'h00;
    data_pointer_16_i = 16'h0000;
    cond_true_i = 1'b0;
    repeat (5) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_data_moves();
    t_cond_branches();
    t_uncond();
    t_nop();
    final_report();
  end

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge mclk_i);
    n_fail++;
    $display("BAD watchdog expected finish seen hang");
    final_report();
  end
endmodule : mit_decoder_bench
`default_nettype wire
